// ===== fpsu_exec.sv
// Execution block for extension-register push, multi-store,
// single store, square root and subtract.
// Assumes the core supplies the decoded instruction, the value of the
// named core register and its flags, and accepts one store word per
// memReady; the register file is filled through the load port.
`timescale 1ns/10ps
// Function
// - push stores listed registers in order
// - push list holds one to sixteen
// - size qualifier must match register width
// - lists are consecutive, one width only
// - square root of single operand
// - multi-store to successive addresses from base
// - increment-after starts at base, goes up
// - decrement-before ends just below base
// - writeback updates base; decrement needs writeback
// - multi-store list one up to sixteen doubles
// - stack pointer accepted as base
// - single store at base plus offset
// - offset signed, word multiple, up to 1020
// - omitted offset means zero
// - executes only when condition holds
// - subtract second from first operand
module fpsu_exec
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 issue,
  input  wire fpsu_pkg::fpsu_instr_t instr,
  input  wire logic [3:0]           flags,
  input  wire logic [31:0]          baseValue,
  input  wire logic                 loadEn,
  input  wire logic [4:0]           loadIdx,
  input  wire logic [31:0]          loadData,
  input  wire logic                 memReady,
  output logic                      memValid,
  output fpsu_pkg::fpsu_memwr_t     memReq,
  output logic                      baseWrEn,
  output logic [3:0]                baseWrIdx,
  output logic [31:0]               baseWrData,
  output logic                      resWrEn,
  output logic [4:0]                resIdx,
  output logic [31:0]               resData,
  output logic                      busy,
  output logic                      done,
  output logic                      illegal
);
  import fpsu_pkg::*;

  // ==========================================================
  // Register file and state
  logic [31:0] regs [0:31];
  fpsu_state_t state, next_state;
  logic [5:0]  wordsLeft, next_wordsLeft;
  logic [4:0]  wordIdx, next_wordIdx;
  logic        wbPending, next_wbPending;
  logic [3:0]  wbIdx, next_wbIdx;
  logic [31:0] wbValue, next_wbValue;
  logic        next_memValid, next_baseWrEn, next_resWrEn;
  logic        next_busy, next_done, next_illegal;
  fpsu_memwr_t next_memReq;
  logic [3:0]  next_baseWrIdx;
  logic [31:0] next_baseWrData, next_resData, arithOut;
  logic [4:0]  next_resIdx;

  logic        accept, condOk, isStore, isArith, legal, downward, doWb;
  logic [6:0]  first7, cnt7;
  logic [5:0]  words;
  logic [4:0]  startIdx;
  logic [31:0] bytes, immOff, startAddr;

  fpsu_arith arith
  (
    .opA     (regs[instr.opA]),
    .opB     (regs[instr.opB]),
    .sqrtSel (instr.op == OP_SQRT),
    .result  (arithOut)
  );

  // ==========================================================
  // Decode
  always_comb
  begin
    accept  = issue && (state == ST_IDLE);
    condOk  = condHolds(instr.cond, flags);
    isStore = instr.op inside {OP_PUSH, OP_STM, OP_STR};
    isArith = instr.op inside {OP_SQRT, OP_SUB};
    first7  = {2'b00, instr.firstReg};
    cnt7    = {1'b0, instr.count};
    legal   = isArith;
    if (isStore)
    begin
      if (instr.op == OP_STR)
        legal = !(instr.dbl && instr.firstReg[4]);
      else
        legal = (instr.count != 6'h0)
             && !(instr.op == OP_PUSH && cnt7 > MAX_LIST)
             && (instr.dbl ? first7 + cnt7 <= MAX_LIST
                           : first7 + cnt7 <= MAX_SINGLES);
      if (instr.sizeGiven && instr.size64 != instr.dbl)
        legal = 1'b0;
      if (instr.op == OP_STM && instr.decBefore && !instr.writeback)
        legal = 1'b0;
    end
    if (instr.op == OP_STR)
      words = instr.dbl ? 6'h2 : 6'h1;
    else
      words = instr.dbl ? {instr.count[4:0], 1'b0} : instr.count;
    startIdx = instr.dbl ? {instr.firstReg[3:0], 1'b0} : instr.firstReg;
    bytes    = blockBytes(words);
    immOff   = {22'h0, instr.immWords, 2'b00};
    // push walks down from the stack pointer
    downward = (instr.op == OP_PUSH)
            || (instr.op == OP_STM && instr.decBefore);
    doWb     = (instr.op == OP_PUSH)
            || (instr.op == OP_STM && instr.writeback);
    if (instr.op == OP_STR)
      startAddr = instr.immAdd ? baseValue + immOff : baseValue - immOff;
    else if (downward)
      startAddr = baseValue - bytes;
    else
      startAddr = baseValue;
  end

  // ==========================================================
  // Sequencer
  always_comb
  begin
    next_state      = state;
    next_wordsLeft  = wordsLeft;
    next_wordIdx    = wordIdx;
    next_wbPending  = wbPending;
    next_wbIdx      = wbIdx;
    next_wbValue    = wbValue;
    next_memValid   = memValid;
    next_memReq     = memReq;
    next_baseWrEn   = 1'b0;
    next_baseWrIdx  = baseWrIdx;
    next_baseWrData = baseWrData;
    next_resWrEn    = 1'b0;
    next_resIdx     = resIdx;
    next_resData    = resData;
    next_done       = 1'b0;
    next_illegal    = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (accept && !legal)
          next_illegal = 1'b1;
        else if (accept && !condOk)
          next_done = 1'b1;
        else if (accept && isArith)
        begin
          next_resWrEn = 1'b1;
          next_done    = 1'b1;
          next_resData = arithOut;
          next_resIdx  = (instr.op == OP_SUB && !instr.destGiven)
                       ? instr.opA : instr.dest;
        end
        else if (accept)
        begin
          next_state     = ST_STORE;
          next_memValid  = 1'b1;
          next_memReq    = '{addr: startAddr, data: regs[startIdx]};
          next_wordsLeft = words;
          next_wordIdx   = startIdx;
          next_wbPending = doWb;
          // push always uses the stack pointer
          next_wbIdx     = (instr.op == OP_PUSH) ? SP_INDEX
                                                 : instr.baseReg;
          next_wbValue   = downward ? baseValue - bytes
                                    : baseValue + bytes;
        end
      end
      ST_STORE:
      begin
        if (memReady)
        begin
          if (wordsLeft == 6'h1)
          begin
            next_state    = ST_IDLE;
            next_memValid = 1'b0;
            next_done     = 1'b1;
            next_baseWrEn   = wbPending;
            next_baseWrIdx  = wbIdx;
            next_baseWrData = wbValue;
          end
          else
          begin
            next_wordsLeft = wordsLeft - 6'h1;
            next_wordIdx   = wordIdx + 5'h1;
            next_memReq    = '{addr: memReq.addr + WORD_BYTES,
                               data: regs[wordIdx + 5'h1]};
          end
        end
      end
      default:
      begin
        next_state    = ST_IDLE;
        next_memValid = 1'b0;
      end
    endcase
    next_busy = next_state == ST_STORE;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      wordsLeft  <= RESET_WORDS;
      wordIdx    <= RESET_IDX;
      wbPending  <= 1'b0;
      wbIdx      <= SP_INDEX;
      wbValue    <= RESET_WORD;
      memValid   <= 1'b0;
      memReq     <= '{addr: RESET_WORD, data: RESET_WORD};
      baseWrEn   <= 1'b0;
      baseWrIdx  <= SP_INDEX;
      baseWrData <= RESET_WORD;
      resWrEn    <= 1'b0;
      resIdx     <= RESET_IDX;
      resData    <= RESET_WORD;
      busy       <= 1'b0;
      done       <= 1'b0;
      illegal    <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      wordsLeft  <= next_wordsLeft;
      wordIdx    <= next_wordIdx;
      wbPending  <= next_wbPending;
      wbIdx      <= next_wbIdx;
      wbValue    <= next_wbValue;
      memValid   <= next_memValid;
      memReq     <= next_memReq;
      baseWrEn   <= next_baseWrEn;
      baseWrIdx  <= next_baseWrIdx;
      baseWrData <= next_baseWrData;
      resWrEn    <= next_resWrEn;
      resIdx     <= next_resIdx;
      resData    <= next_resData;
      busy       <= next_busy;
      done       <= next_done;
      illegal    <= next_illegal;
    end
  end

  // Arithmetic result wins over a load to the same cycle
  always_ff @(posedge clock)
  begin
    if (next_resWrEn)
      regs[next_resIdx] <= next_resData;
    else if (loadEn)
      regs[loadIdx] <= loadData;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence takeOp(fpsu_op_t o);
    accept && legal && condOk && instr.op == o;
  endsequence

  sequence lastBeat;
    state == ST_STORE && memReady && wordsLeft == 6'h1;
  endsequence

  AST_COND_SKIP:
    assert property (accept && legal && !condOk
                     |=> done && !memValid && !resWrEn)
      else $error("store or result despite failed condition");
  AST_PUSH_RANGE:
    assert property (accept && instr.op == OP_PUSH
                     && (instr.count == 6'h0 || instr.count > 6'h10)
                     |=> illegal && !memValid)
      else $error("bad push list not refused");
  AST_SIZE_MATCH:
    assert property (accept && isStore && instr.sizeGiven
                     && instr.size64 != instr.dbl |=> illegal)
      else $error("size mismatch not refused");
  AST_DB_NEEDS_WB:
    assert property (accept && instr.op == OP_STM && instr.decBefore
                     && !instr.writeback |=> illegal)
      else $error("decrement without writeback accepted");
  AST_IA_START:
    assert property (takeOp(OP_STM) and (!instr.decBefore)
                     |=> memValid && memReq.addr == $past(baseValue))
      else $error("increment-after start address wrong");
  AST_PUSH_BELOW_SP:
    assert property (takeOp(OP_PUSH)
                     |=> memReq.addr == $past(baseValue) - $past(bytes)
                         && wbIdx == SP_INDEX && wbPending)
      else $error("push block not below stack pointer");
  AST_STEP_UP:
    assert property (state == ST_STORE && memReady && wordsLeft > 6'h1
                     |=> memValid
                         && memReq.addr == $past(memReq.addr) + 32'h4)
      else $error("store address did not advance one word");
  AST_WB_AFTER_LAST:
    assert property (lastBeat and wbPending
                     |=> baseWrEn && baseWrData == $past(wbValue)
                         ##1 !baseWrEn)
      else $error("writeback missing after last word");
  AST_STR_ADDR:
    assert property (takeOp(OP_STR) ##0 instr.immAdd
                     |=> memReq.addr
                         == $past(baseValue)
                            + {22'h0, $past(instr.immWords), 2'b00})
      else $error("single store address wrong");
  AST_SQRT_DEST:
    assert property (takeOp(OP_SQRT)
                     |=> resWrEn && resIdx == $past(instr.dest))
      else $error("square root result not written");

endmodule

// ===== fpsu_pkg.sv
// Shared types and constants for the floating-point store, push,
// square-root and subtract execution block.
// Assumes the core decodes instruction fields into fpsu_instr_t.
package fpsu_pkg;

  // ==========================================================
  // Operations and sequencer states
  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_PUSH = 3'h1,
    OP_STM  = 3'h2,
    OP_STR  = 3'h3,
    OP_SQRT = 3'h4,
    OP_SUB  = 3'h5
  } fpsu_op_t;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b01,
    ST_STORE = 2'b10
  } fpsu_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed
  {
    fpsu_op_t   op;
    logic [3:0] cond;
    logic       sizeGiven;
    logic       size64;
    logic       dbl;
    logic [4:0] firstReg;
    logic [5:0] count;
    logic       decBefore;
    logic       writeback;
    logic [3:0] baseReg;
    logic       immAdd;
    logic [7:0] immWords;
    logic       destGiven;
    logic [4:0] dest;
    logic [4:0] opA;
    logic [4:0] opB;
  } fpsu_instr_t;

  typedef struct packed
  {
    logic [31:0] addr;
    logic [31:0] data;
  } fpsu_memwr_t;

  // ==========================================================
  // Constants
  localparam logic [3:0]  SP_INDEX      = 4'hD;
  localparam logic [6:0]  MAX_SINGLES   = 7'h20;
  localparam logic [6:0]  MAX_LIST      = 7'h10;
  localparam logic [31:0] WORD_BYTES    = 32'h4;
  localparam logic [31:0] FP_QNAN       = 32'h7FC00000;
  localparam logic [9:0]  EXP_BIAS      = 10'h07F;
  localparam logic [7:0]  EXP_MAX       = 8'hFF;
  localparam logic [31:0] RESET_WORD    = 32'h0;
  localparam logic [4:0]  RESET_IDX     = 5'h0;
  localparam logic [5:0]  RESET_WORDS   = 6'h0;

  // Bytes in a block of 32-bit words
  function automatic logic [31:0] blockBytes(input logic [5:0] words);
    blockBytes = {24'h0, words, 2'b00};
  endfunction

  // Condition code against core flags {N,Z,C,V}
  function automatic logic condHolds(input logic [3:0] cond,
                                     input logic [3:0] nzcv);
    logic n, z, c, v;
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    case (cond)
      4'h0:    condHolds = z;
      4'h1:    condHolds = !z;
      4'h2:    condHolds = c;
      4'h3:    condHolds = !c;
      4'h4:    condHolds = n;
      4'h5:    condHolds = !n;
      4'h6:    condHolds = v;
      4'h7:    condHolds = !v;
      4'h8:    condHolds = c && !z;
      4'h9:    condHolds = !c || z;
      4'hA:    condHolds = n == v;
      4'hB:    condHolds = n != v;
      4'hC:    condHolds = !z && (n == v);
      4'hD:    condHolds = z || (n != v);
      default: condHolds = 1'b1;
    endcase
  endfunction

endpackage

// ===== fpsu_arith.sv
// Single-precision subtract and square root, combinational.
// Assumes the caller registers the result; denormals flush to zero, save a denormal opB when opA's exponent is zero,
// rounding truncates, infinities and NaNs give the default NaN.
`timescale 1ns/10ps
module fpsu_arith
(
  input  wire logic [31:0] opA,
  input  wire logic [31:0] opB,
  input  wire logic        sqrtSel,
  output logic      [31:0] result
);
  import fpsu_pkg::*;

  logic        sx, sy, swap;
  logic [7:0]  ex, ey, ediff;
  logic [26:0] mx, my, mag;
  logic [27:0] sum;
  logic [9:0]  eRes, eUnb;
  logic [47:0] rad;
  logic [25:0] rem, trial;
  logic [23:0] root;
  logic        found;

  always_comb
  begin
    sx = 1'b0; sy = 1'b0; swap = 1'b0; ex = 8'h0; ey = 8'h0;
    ediff = 8'h0; mx = 27'h0; my = 27'h0; mag = 27'h0; sum = 28'h0;
    eRes = 10'h0; eUnb = 10'h0; rad = 48'h0; rem = 26'h0;
    trial = 26'h0; root = 24'h0; found = 1'b0;
    result = RESET_WORD;
    if (sqrtSel)
    begin
      if (opA[30:23] == 8'h0)
        result = {opA[31], 31'h0};
      else if (opA[31] || opA[30:23] == EXP_MAX)
        result = FP_QNAN;
      else
      begin
        eUnb = {2'b00, opA[30:23]} - EXP_BIAS;
        rad  = {24'h0, 1'b1, opA[22:0]} << 23;
        if (eUnb[0])
        begin
          rad  = rad << 1;
          eUnb = eUnb - 10'h1;
        end
        for (int i = 23; i >= 0; i--)
        begin
          rem   = {rem[23:0], rad[2*i+1 -: 2]};
          trial = {root[23:0], 2'b01};
          if (rem >= trial)
          begin
            rem  = rem - trial;
            root = {root[22:0], 1'b1};
          end
          else
            root = {root[22:0], 1'b0};
        end
        eRes   = {eUnb[9], eUnb[9:1]} + EXP_BIAS;
        result = {1'b0, eRes[7:0], root[22:0]};
      end
    end
    else
    begin
      swap = opB[30:0] > opA[30:0];
      sx = swap ? !opB[31] : opA[31];
      sy = swap ? opA[31] : !opB[31];
      ex = swap ? opB[30:23] : opA[30:23];
      ey = swap ? opA[30:23] : opB[30:23];
      mx = swap ? {1'b1, opB[22:0], 3'b000} : {1'b1, opA[22:0], 3'b000};
      my = swap ? {1'b1, opA[22:0], 3'b000} : {1'b1, opB[22:0], 3'b000};
      if (ey == 8'h0)
        my = 27'h0;
      ediff = ex - ey;
      my = (ediff > 8'h1A) ? 27'h0 : my >> ediff;
      sum = (sx == sy) ? {1'b0, mx} + {1'b0, my} : {1'b0, mx} - {1'b0, my};
      eRes = {2'b00, ex};
      if (sum[27])
      begin
        mag  = sum[27:1];
        eRes = eRes + 10'h1;
      end
      else
      begin
        mag = sum[26:0];
        for (int i = 0; i < 27; i++)
          if (!found && !mag[26] && eRes > 10'h1)
          begin
            mag  = {mag[25:0], 1'b0};
            eRes = eRes - 10'h1;
          end
          else
            found = 1'b1;
      end
      if (ex == EXP_MAX || ey == EXP_MAX || eRes >= {2'b00, EXP_MAX})
        result = FP_QNAN;
      else if (ex == 8'h0)
        result = {!opB[31], opB[30:0]};
      else if (!mag[26])
        result = RESET_WORD;
      else
        result = {sx, eRes[7:0], mag[25:3]};
    end
  end

endmodule

// ===== fpsu_mem_model.sv
// Memory side of the store port: accepts store words and keeps a log.
// Assumes the block holds each word until memReady; stall sets waits.
`timescale 1ns/10ps
module fpsu_mem_model
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [1:0]            stall,
  input  wire logic                  memValid,
  input  wire fpsu_pkg::fpsu_memwr_t memReq,
  output logic                       memReady
);
  import fpsu_pkg::*;
  logic [1:0]  waitCnt;
  logic [31:0] wrAddr [0:63];
  logic [31:0] wrData [0:63];
  int          wrCount = 0;

  // ==========================================================
  // Handshake and log
  // Ready only toward an offered word; a slow memory forces a hold
  assign memReady = memValid && (waitCnt == stall);

  always @(posedge clock)
  begin
    if (rst || !memValid || memReady)
      waitCnt <= 2'h0;
    else
      waitCnt <= waitCnt + 2'h1;
    if (!rst && memValid && memReady && wrCount < 64)
    begin
      wrAddr[wrCount] <= memReq.addr;
      wrData[wrCount] <= memReq.data;
      wrCount <= wrCount + 1;
    end
  end
endmodule

// ===== fpsu_tb.sv
// Self-checking bench for the store, push and arithmetic block.
// Assumes the memory model logs the first 64 accepted store words.
`timescale 1ns/10ps
module testbench;
  import fpsu_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        issue = 1'b0;
  fpsu_instr_t instr = '0;
  logic [3:0]  flags = 4'h0;
  logic [31:0] baseValue = 32'h0;
  logic        loadEn = 1'b0;
  logic [4:0]  loadIdx = 5'h0;
  logic [31:0] loadData = 32'h0;
  logic [1:0]  stall = 2'h0;
  logic        memReady, memValid, baseWrEn, resWrEn, busy, done, illegal;
  fpsu_memwr_t memReq;
  logic [3:0]  baseWrIdx, wbI;
  logic [4:0]  resIdx, resI;
  logic [31:0] baseWrData, resData, wbD, resD;
  logic        sawIll, sawDone, sawRes, sawWb, busyAt1;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          firstWord, i;

  fpsu_exec DUT
  (
    .clock(clock), .rst(rst), .issue(issue), .instr(instr),
    .flags(flags), .baseValue(baseValue), .loadEn(loadEn),
    .loadIdx(loadIdx), .loadData(loadData), .memReady(memReady),
    .memValid(memValid), .memReq(memReq), .baseWrEn(baseWrEn),
    .baseWrIdx(baseWrIdx), .baseWrData(baseWrData),
    .resWrEn(resWrEn), .resIdx(resIdx), .resData(resData),
    .busy(busy), .done(done), .illegal(illegal)
  );

  fpsu_mem_model memModel
  (
    .clock(clock), .rst(rst), .stall(stall), .memValid(memValid),
    .memReq(memReq), .memReady(memReady)
  );

  always #12.5 clock = ~clock;

  // ==========================================================
  // Reporting
  task automatic results;
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang anywhere ends the run here; whole run needs about 200
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      results;
    end
  end

  task automatic chk32(input string name, input logic [31:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkBit(input string name, input logic exp, got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // ==========================================================
  // Drivers
  function automatic logic [31:0] regVal(input int idx);
    regVal = 32'h5A3C0000 + 32'(idx) * 32'h101;
  endfunction

  function automatic fpsu_instr_t mk(input fpsu_op_t op, input logic dbl,
                                     input logic [4:0] first,
                                     input logic [5:0] count);
    mk = '0;
    mk.op = op;
    mk.cond = 4'hE;
    mk.dbl = dbl;
    mk.firstReg = first;
    mk.count = count;
  endfunction

  task automatic loadReg(input logic [4:0] idx, input logic [31:0] d);
    @(negedge clock);
    loadEn = 1'b1;
    loadIdx = idx;
    loadData = d;
    @(negedge clock);
    loadEn = 1'b0;
  endtask

  // Issue one instruction and collect its pulses until done or refusal
  task automatic run(input fpsu_instr_t ins, input logic [31:0] base);
    int n;
    firstWord = memModel.wrCount;
    @(negedge clock);
    issue = 1'b1;
    instr = ins;
    baseValue = base;
    @(negedge clock);
    issue = 1'b0;
    busyAt1 = busy;
    {sawIll, sawDone, sawRes, sawWb} = 4'h0;
    for (n = 0; n < 200; n++)
    begin
      sawRes = sawRes | (resWrEn === 1'b1);
      resI = (resWrEn === 1'b1) ? resIdx : resI;
      resD = (resWrEn === 1'b1) ? resData : resD;
      sawWb = sawWb | (baseWrEn === 1'b1);
      wbI = (baseWrEn === 1'b1) ? baseWrIdx : wbI;
      wbD = (baseWrEn === 1'b1) ? baseWrData : wbD;
      sawIll = sawIll | (illegal === 1'b1);
      sawDone = sawDone | (done === 1'b1);
      if (sawIll || sawDone)
        break;
      @(negedge clock);
    end
    chkBit("completion", 1'b1, sawIll | sawDone);
  endtask

  // Words go out in register order, ascending by one word each
  task automatic chkStore(input fpsu_instr_t ins, input logic [31:0] start,
                          input logic expWb, input logic [31:0] wbData);
    int words, first, k, w;
    logic [3:0] expIdx;
    words = ins.dbl ? 2 * ins.count : ins.count;
    first = ins.dbl ? 2 * ins.firstReg : ins.firstReg;
    chk32("word count", words, memModel.wrCount - firstWord);
    for (k = 0; k < words; k++)
    begin
      w = firstWord + k;
      chk32("addr", start + 4 * k, memModel.wrAddr[w]);
      chk32("data", regVal(first + k), memModel.wrData[w]);
    end
    chkBit("done", 1'b1, sawDone);
    chkBit("busy", 1'b1, busyAt1);
    chkBit("idle after", 1'b0, busy);
    chkBit("base write", expWb, sawWb);
    // push writes back the stack pointer
    expIdx = (ins.op == OP_PUSH) ? SP_INDEX : ins.baseReg;
    if (expWb)
    begin
      chk32("base index", {28'h0, expIdx}, {28'h0, wbI});
      chk32("base value", wbData, wbD);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic testPush;
    fpsu_instr_t ins;
    ins = mk(OP_PUSH, 1'b1, 5'h0, 6'h10);
    run(ins, 32'h20000100);
    chkStore(ins, 32'h20000080, 1'b1, 32'h20000080);
  endtask

  task automatic testStm;
    fpsu_instr_t ins;
    stall = 2'h2;
    ins = mk(OP_STM, 1'b0, 5'd29, 6'h3);
    ins.writeback = 1'b1;
    ins.baseReg = 4'h5;
    run(ins, 32'h30000000);
    chkStore(ins, 32'h30000000, 1'b1, 32'h3000000C);
    stall = 2'h1;
    ins = mk(OP_STM, 1'b1, 5'h3, 6'h1);
    {ins.decBefore, ins.writeback, ins.sizeGiven, ins.size64} = 4'hF;
    run(ins, 32'h30000040);
    chkStore(ins, 32'h30000038, 1'b1, 32'h30000038);
    stall = 2'h0;
    ins = mk(OP_STM, 1'b0, 5'h0, 6'h1);
    ins.baseReg = SP_INDEX;
    run(ins, 32'h20000010);
    chkStore(ins, 32'h20000010, 1'b0, 32'h0);
  endtask

  task automatic testStr;
    fpsu_instr_t ins;
    ins = mk(OP_STR, 1'b0, 5'h7, 6'h1);
    ins.immWords = 8'hFF;
    ins.baseReg = SP_INDEX;
    run(ins, 32'h40000400);
    chkStore(ins, 32'h40000004, 1'b0, 32'h0);
    ins = mk(OP_STR, 1'b1, 5'h2, 6'h1);
    ins.immAdd = 1'b1;
    ins.baseReg = 4'h3;
    run(ins, 32'h40000400);
    chkStore(ins, 32'h40000400, 1'b0, 32'h0);
  endtask

  task automatic testIllegal;
    fpsu_instr_t bad [7];
    int k;
    bad[0] = mk(OP_PUSH, 1'b0, 5'h0, 6'h11);
    bad[1] = mk(OP_STM, 1'b0, 5'h4, 6'h0);
    bad[2] = mk(OP_STM, 1'b1, 5'hF, 6'h2);
    bad[3] = mk(OP_PUSH, 1'b0, 5'h0, 6'h2);
    {bad[3].sizeGiven, bad[3].size64} = 2'b11;
    bad[4] = mk(OP_STM, 1'b0, 5'h0, 6'h2);
    bad[4].decBefore = 1'b1;
    bad[5] = mk(OP_NONE, 1'b0, 5'h0, 6'h1);
    bad[6] = mk(OP_STR, 1'b1, 5'h10, 6'h1);
    for (k = 0; k < 7; k++)
    begin
      run(bad[k], 32'h50000000);
      chkBit("bad", 1'b1, sawIll);
      chk32("stray words", 32'h0, memModel.wrCount - firstWord);
    end
  endtask

  task automatic testCond;
    fpsu_instr_t ins;
    flags = 4'h0;
    ins = mk(OP_PUSH, 1'b0, 5'h0, 6'h1);
    ins.baseReg = SP_INDEX;
    ins.cond = 4'h0;
    run(ins, 32'h20000100);
    chkBit("skip done", 1'b1, sawDone);
    chkBit("skip base write", 1'b0, sawWb);
    chk32("skip words", 32'h0, memModel.wrCount - firstWord);
    ins.cond = 4'h1;
    run(ins, 32'h20000100);
    chkStore(ins, 32'h200000FC, 1'b1, 32'h200000FC);
    flags = 4'h4;
    ins = mk(OP_SUB, 1'b0, 5'h0, 6'h1);
    ins.cond = 4'h1;
    run(ins, 32'h0);
    chkBit("skip result", 1'b0, sawRes);
  endtask

  task automatic testArith;
    fpsu_instr_t ins;
    loadReg(5'd20, 32'h40400000);
    loadReg(5'd21, 32'h3F800000);
    loadReg(5'd22, 32'h40800000);
    ins = mk(OP_SUB, 1'b0, 5'h0, 6'h1);
    ins.opA = 5'd20;
    ins.opB = 5'd21;
    run(ins, 32'h0);
    chkBit("sub result", 1'b1, sawRes);
    chk32("sub index", 32'd20, {27'h0, resI});
    chk32("sub value", 32'h40000000, resD);
    ins = mk(OP_SQRT, 1'b0, 5'h0, 6'h1);
    {ins.opA, ins.opB} = {5'd22, 5'd22};
    ins.destGiven = 1'b1;
    ins.dest = 5'd23;
    run(ins, 32'h0);
    chk32("sqrt index", 32'd23, {27'h0, resI});
    chk32("sqrt value", 32'h40000000, resD);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chkBit("idle busy", 1'b0, busy);
    for (i = 0; i < 32; i++)
      loadReg(5'(i), regVal(i));
    testPush;
    testStm;
    testStr;
    testIllegal;
    testCond;
    testArith;
    results;
  end
endmodule
